// ==== bbse_map.svh ====
/*
  constant map for the byte, branch and skip execution unit.
  assumes inclusion by bare name from the package and design modules.
*/
`ifndef BBSE_MAP_SVH
`define BBSE_MAP_SVH

// opcode field positions
`define BBSE_OP_HI        15
`define BBSE_OP_LO        10
`define BBSE_D_BIT        9
`define BBSE_A_BIT        8
`define BBSE_BIT_HI       11
`define BBSE_BIT_LO       9

// opcode patterns, upper six bits
`define BBSE_OP_ADDC      6'h08
`define BBSE_OP_DECSZ     6'h0B
`define BBSE_OP_DECSNZ    6'h13
// upper eight bits for literal and branch groups
`define BBSE_OP8_ANDL     8'h0B
`define BBSE_OP8_BRANCH_NO_OVERFLOW     8'hE5
`define BBSE_OP8_BNZ      8'hE1
// upper four bits for bit tests
`define BBSE_OP4_BTSC     4'hB
`define BBSE_OP4_BTSS     4'hA

// indexed literal offset limit
`define BBSE_ILO_MAX      8'h5F
// access bank split: low half maps to bank zero, high half to top bank
`define BBSE_ACC_SPLIT    8'h80
`define BBSE_TOP_BANK     4'hF
// program counter step per instruction word
`define BBSE_PC_STEP      21'h000002
`define BBSE_PC_RESET     21'h000000
`define BBSE_BYTE_ZERO    8'h00
`define BBSE_BYTE_ONE     8'h01
`define BBSE_NOP_WORD     16'h0000

`endif

// ==== bbse_pkg.sv ====
/*
  types shared by the execution unit and its address former.
  assumes bbse_map.svh is on the include path.
*/
`default_nettype none
`include "bbse_map.svh"

package bbse_pkg;

    // decoded instruction class
    typedef enum logic [3:0] {
        BBSE_I_OTHER  = 4'b0000,
        BBSE_I_ADDC   = 4'b0001,
        BBSE_I_ANDL   = 4'b0010,
        BBSE_I_BRANCH_NO_OVERFLOW   = 4'b0011,
        BBSE_I_BNZ    = 4'b0100,
        BBSE_I_BTSC   = 4'b0101,
        BBSE_I_BTSS   = 4'b0110,
        BBSE_I_DECSZ  = 4'b0111,
        BBSE_I_DECSNZ = 4'b1000
    } bbse_instr_t;

    // execution sequencer state
    typedef enum logic [1:0] {
        BBSE_S_EXEC  = 2'b00,
        BBSE_S_NOP1  = 2'b01,
        BBSE_S_NOP2  = 2'b10
    } bbse_state_t;

    // data memory request, one per executed cycle
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } bbse_mem_req_t;

    // status flags read and written by the unit
    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } bbse_flags_t;

endpackage

`default_nettype wire

// ==== bbse_addr.sv ====
/*
  forms the 12-bit data memory address of a file operand.
  assumes operand, bank select and index pointer are stable within the cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bbse_map.svh"

module bbse_addr
    import bbse_pkg::*;
(
    // operand fields
    input  wire logic [7:0]  f_operand,
    input  wire logic        access_sel,
    // mode and bank state
    input  wire logic        ext_set_en,
    input  wire logic [3:0]  bank_select_reg,
    input  wire logic [11:0] index_ptr,
    // resulting address
    output logic      [11:0] addr
);

    // address choice: indexed, banked or access bank
    always_comb begin
        if (!access_sel && ext_set_en && f_operand <= `BBSE_ILO_MAX) begin
            addr = index_ptr + {4'h0, f_operand};
        end else if (access_sel) begin
            addr = {bank_select_reg, f_operand};
        end else if (f_operand < `BBSE_ACC_SPLIT) begin
            addr = {4'h0, f_operand};
        end else begin
            addr = {`BBSE_TOP_BANK, f_operand};
        end
    end

endmodule

`default_nettype wire

// ==== bbse_exec.sv ====
/*
  execution unit for add with carry, and literal, two conditional branches,
  bit-test skips and decrement skips, including the skip nop cycles.
  assumes one sys_clk edge per instruction cycle, instr_valid with the fetched
  word, and data memory read data returned combinationally for the file operand address of instr_word.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bbse_map.svh"

module bbse_exec
    import bbse_pkg::*;
(
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          reset,
    // fetch side
    input  wire logic          instr_valid,
    input  wire logic [15:0]   instr_word,
    input  wire logic          next_two_word,
    input  wire logic [20:0]   pc_incr,
    // mode and bank state
    input  wire logic          ext_set_en,
    input  wire logic [3:0]    bank_select_reg,
    input  wire logic [11:0]   index_ptr,
    // data memory read data
    input  wire logic [7:0]    mem_rdata,
    // data memory request
    output bbse_mem_req_t      mem_req,
    // architectural state
    output logic      [7:0]    acc,
    output bbse_flags_t        flags,
    // program flow
    output logic               pc_load,
    output logic      [20:0]   pc_target,
    output logic               nop_cycle,
    output logic               busy
);

    // decoded fields
    bbse_instr_t   kind;          // instruction class
    logic [11:0]   file_addr;     // formed file address
    logic [7:0]    sum;           // add result
    logic          sum_c;         // add carry out
    logic [7:0]    dec;           // decrement result
    logic [7:0]    result;        // byte result to write
    logic          take;          // branch taken
    logic          skip;          // skip condition
    logic          bitval;        // tested bit

    // registered state
    bbse_state_t   state;
    bbse_state_t   next_state;
    logic          two_word_pend;
    logic          next_two_word_pend;
    logic [7:0]    next_acc;
    bbse_flags_t   next_flags;
    bbse_mem_req_t next_mem_req;
    logic          next_pc_load;
    logic [20:0]   next_pc_target;
    logic          next_nop_cycle;
    logic          next_busy;

    // opcode class decode
    function automatic bbse_instr_t decode(input logic [15:0] w);
        if (w[`BBSE_OP_HI:`BBSE_OP_LO] == `BBSE_OP_ADDC)        decode = BBSE_I_ADDC;
        else if (w[`BBSE_OP_HI:`BBSE_OP_LO] == `BBSE_OP_DECSZ)  decode = BBSE_I_DECSZ;
        else if (w[`BBSE_OP_HI:`BBSE_OP_LO] == `BBSE_OP_DECSNZ) decode = BBSE_I_DECSNZ;
        else if (w[15:8] == `BBSE_OP8_ANDL)                      decode = BBSE_I_ANDL;
        else if (w[15:8] == `BBSE_OP8_BRANCH_NO_OVERFLOW)                      decode = BBSE_I_BRANCH_NO_OVERFLOW;
        else if (w[15:8] == `BBSE_OP8_BNZ)                       decode = BBSE_I_BNZ;
        else if (w[15:12] == `BBSE_OP4_BTSC)                     decode = BBSE_I_BTSC;
        else if (w[15:12] == `BBSE_OP4_BTSS)                     decode = BBSE_I_BTSS;
        else                                                     decode = BBSE_I_OTHER;
    endfunction

    // relative target: signed offset doubled onto incremented pc
    function automatic logic [20:0] rel_target(input logic [20:0] pc, input logic [7:0] n);
        rel_target = pc + {{12{n[7]}}, n, 1'b0};
    endfunction

    // address former
    bbse_addr u_addr (
        .f_operand       (instr_word[7:0]),
        .access_sel      (instr_word[`BBSE_A_BIT]),
        .ext_set_en      (ext_set_en),
        .bank_select_reg (bank_select_reg),
        .index_ptr       (index_ptr),
        .addr            (file_addr)
    );

    // datapath: results and conditions for the current word
    always_comb begin
        kind   = decode(instr_word);
        {sum_c, sum} = {1'b0, acc} + {1'b0, mem_rdata} + {8'h00, flags.c};
        dec    = mem_rdata - `BBSE_BYTE_ONE;
        bitval = mem_rdata[instr_word[`BBSE_BIT_HI:`BBSE_BIT_LO]];
        result = (kind == BBSE_I_ADDC) ? sum : dec;
        take   = (kind == BBSE_I_BRANCH_NO_OVERFLOW && !flags.ov)
              || (kind == BBSE_I_BNZ && !flags.z);
        skip   = (kind == BBSE_I_BTSC && !bitval)
              || (kind == BBSE_I_BTSS && bitval)
              || (kind == BBSE_I_DECSZ && dec == `BBSE_BYTE_ZERO)
              || (kind == BBSE_I_DECSNZ && dec != `BBSE_BYTE_ZERO);
    end

    // next-state and output computation
    always_comb begin
        next_state         = state;
        next_two_word_pend = two_word_pend;
        next_acc           = acc;
        next_flags         = flags;
        next_mem_req       = '0;
        next_pc_load       = 1'b0;
        next_pc_target     = pc_target;
        next_nop_cycle     = 1'b0;
        next_busy          = 1'b0;
        // rd flags, one cycle late, that a file operand was read
        case (state)
            BBSE_S_EXEC: begin
                if (instr_valid) begin
                    case (kind)
                        BBSE_I_ADDC, BBSE_I_DECSZ, BBSE_I_DECSNZ: begin
                            if (instr_word[`BBSE_D_BIT]) begin
                                next_mem_req.wr    = 1'b1;
                                next_mem_req.addr  = file_addr;
                                next_mem_req.wdata = result;
                            end else begin
                                next_acc = result;
                            end
                            if (kind == BBSE_I_ADDC) begin
                                next_flags.c  = sum_c;
                                next_flags.dc = (acc[3:0] + mem_rdata[3:0]
                                                 + {3'h0, flags.c}) > 5'h0F;
                                next_flags.z  = (sum == `BBSE_BYTE_ZERO);
                                next_flags.n  = sum[7];
                                next_flags.ov = (acc[7] == mem_rdata[7])
                                                && (sum[7] != acc[7]);
                            end
                        end
                        BBSE_I_ANDL: begin
                            next_acc     = acc & instr_word[7:0];
                            next_flags.z = ((acc & instr_word[7:0]) == `BBSE_BYTE_ZERO);
                            next_flags.n = acc[7] & instr_word[7];
                        end
                        default: begin
                        end
                    endcase
                    if (take) begin
                        next_pc_load   = 1'b1;
                        next_pc_target = rel_target(pc_incr, instr_word[7:0]);
                        next_state     = BBSE_S_NOP1;
                        next_busy      = 1'b1;
                        next_two_word_pend = 1'b0;
                    end else if (skip) begin
                        next_state         = BBSE_S_NOP1;
                        next_busy          = 1'b1;
                        next_two_word_pend = next_two_word;
                    end
                end
            end
            BBSE_S_NOP1: begin
                next_nop_cycle = 1'b1;
                if (two_word_pend) begin
                    next_state = BBSE_S_NOP2;
                    next_busy  = 1'b1;
                end else begin
                    next_state = BBSE_S_EXEC;
                end
            end
            BBSE_S_NOP2: begin
                next_nop_cycle     = 1'b1;
                next_two_word_pend = 1'b0;
                next_state         = BBSE_S_EXEC;
            end
            default: begin
                next_state = BBSE_S_EXEC;
            end
        endcase
        // file operand read accompanies every executed file instruction
        if (state == BBSE_S_EXEC && instr_valid
            && (kind == BBSE_I_ADDC || kind == BBSE_I_DECSZ || kind == BBSE_I_DECSNZ
                || kind == BBSE_I_BTSC || kind == BBSE_I_BTSS)) begin
            next_mem_req.rd = 1'b1;
        end
    end

    // state registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state         <= BBSE_S_EXEC;
            two_word_pend <= 1'b0;
            acc           <= `BBSE_BYTE_ZERO;
            flags         <= '0;
            mem_req       <= '0;
            pc_load       <= 1'b0;
            pc_target     <= `BBSE_PC_RESET;
            nop_cycle     <= 1'b0;
            busy          <= 1'b0;
        end else begin
            state         <= next_state;
            two_word_pend <= next_two_word_pend;
            acc           <= next_acc;
            flags         <= next_flags;
            mem_req       <= next_mem_req;
            pc_load       <= next_pc_load;
            pc_target     <= next_pc_target;
            nop_cycle     <= next_nop_cycle;
            busy          <= next_busy;
        end
    end

endmodule

`default_nettype wire

// ==== bbse_exec_props.sv ====
/*
  checker of the execution unit's branch, skip and result timing.
  assumes it is bound to bbse_exec and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module bbse_exec_props
    import bbse_pkg::*;
(
    // clock, reset and fetch side
    input wire logic          sys_clk,
    input wire logic          reset,
    input wire logic          instr_valid,
    input wire logic [15:0]   instr_word,
    input wire logic          next_two_word,
    input wire logic [20:0]   pc_incr,
    // memory and results
    input wire logic [7:0]    mem_rdata,
    input wire bbse_mem_req_t mem_req,
    input wire logic [7:0]    acc,
    input wire bbse_flags_t   flags,
    input wire logic          pc_load,
    input wire logic [20:0]   pc_target,
    input wire logic          nop_cycle,
    input wire logic          busy
);
    logic       take;  // word accepted at this edge
    logic [7:0] op8;   // upper opcode byte
    logic       tbit;  // tested file bit
    assign take = instr_valid && !busy && !nop_cycle && !pc_load;
    assign op8 = instr_word[15:8];
    assign tbit = mem_rdata[instr_word[11:9]];
    logic [20:0] rel_tgt;  // target from doubled signed offset
    logic [7:0]  and_res;  // literal and accumulator
    logic [7:0]  add_res;  // accumulator, file byte and carry
    assign rel_tgt = pc_incr + {{12{instr_word[7]}}, instr_word[7:0], 1'b0};
    assign and_res = acc & instr_word[7:0];
    assign add_res = 8'(acc + mem_rdata + flags.c);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    nov_taken_a : assert property (
        take && op8 == 8'hE5 && !flags.ov |=> pc_load && pc_target ==
        $past(rel_tgt))
        else $error("overflow branch target wrong");
    nov_held_a : assert property (
        take && op8 == 8'hE5 && flags.ov |=> !pc_load && !busy)
        else $error("overflow branch taken");
    nz_taken_a : assert property (
        take && op8 == 8'hE1 && !flags.z |=> pc_load && pc_target ==
        $past(rel_tgt))
        else $error("nonzero branch target wrong");
    taken_nop_a : assert property (
        pc_load |=> !pc_load && nop_cycle ##1 !nop_cycle)
        else $error("taken branch nop count wrong");
    and_lit_a : assert property (
        take && op8 == 8'h0B |=> acc == $past(and_res))
        else $error("and literal result wrong");
    add_acc_a : assert property (
        take && instr_word[15:9] == 7'h10 |=> !mem_req.wr &&
        acc == $past(add_res))
        else $error("add to accumulator wrong");
    add_file_a : assert property (
        take && instr_word[15:9] == 7'h11 |=> mem_req.wr && $stable(acc) &&
        mem_req.wdata == $past(add_res))
        else $error("add to file wrong");
    skip_one_a : assert property (
        take && instr_word[15:12] == 4'hB && !tbit && !next_two_word
        |=> busy ##1 nop_cycle ##1 !nop_cycle)
        else $error("single skip nop wrong");
    skip_two_a : assert property (
        take && instr_word[15:12] == 4'hA && tbit && next_two_word
        |=> busy ##1 nop_cycle [*2] ##1 !nop_cycle)
        else $error("double skip nop wrong");
    dec_zero_a : assert property (
        take && instr_word[15:9] == 7'h17 && mem_rdata == 8'h01
        |=> mem_req.wr && mem_req.wdata == 8'h00 && busy)
        else $error("decrement skip wrong");
endmodule
bind bbse_exec bbse_exec_props bbse_exec_props_i (
    .sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid),
    .instr_word(instr_word), .next_two_word(next_two_word), .pc_incr(pc_incr),
    .mem_rdata(mem_rdata), .mem_req(mem_req), .acc(acc), .flags(flags),
    .pc_load(pc_load), .pc_target(pc_target), .nop_cycle(nop_cycle), .busy(busy)
);
`default_nettype wire

// ==== bbse_mem_model.sv ====
/*
  banked data memory answering the unit's file operand reads.
  assumes result writes land on the edge that samples mem_req.wr.
*/
`timescale 1ns/1ps
`default_nettype none
module bbse_mem_model
    import bbse_pkg::*;
(
    // clock and request
    input  wire logic          sys_clk,
    input  wire bbse_mem_req_t mem_req,
    // operand and bank state
    input  wire logic [15:0]   instr_word,
    input  wire logic          ext_set_en,
    input  wire logic [3:0]    bank_select_reg,
    input  wire logic [11:0]   index_ptr,
    // read data
    output logic      [7:0]    mem_rdata
);
    logic [7:0]  mem [4096];  // whole data space
    logic [11:0] rd_addr;     // formed file address
    logic [7:0]  f;           // file operand
    assign f = instr_word[7:0];
    // fill with a known pattern
    initial begin
        for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'hA5;
    end
    // read address forming
    always_comb begin
        if (instr_word[8]) begin
            rd_addr = {bank_select_reg, f};
        end else if (ext_set_en && f <= 8'h5F) begin
            rd_addr = index_ptr + {4'h0, f};
        end else begin
            rd_addr = {(f[7] ? 4'hF : 4'h0), f};
        end
    end
    assign mem_rdata = mem[rd_addr];
    // result write back
    always @(posedge sys_clk) begin
        if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
    end
endmodule
`default_nettype wire

// ==== bbse_tb.sv ====
/*
  self-checking bench of the execution unit with a memory model.
  assumes inputs change on the falling edge of sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
    import bbse_pkg::*;
;
    logic          sys_clk = 1'b0, reset = 1'b1, instr_valid = 1'b0;
    logic [15:0]   instr_word = 16'h0000;
    logic          next_two_word = 1'b0, ext_set_en = 1'b0;
    logic [20:0]   pc_incr = 21'h000100;
    logic [3:0]    bank_select_reg = 4'h3;
    logic [11:0]   index_ptr = 12'h200;
    logic [7:0]    mem_rdata, acc;
    bbse_mem_req_t mem_req;
    bbse_flags_t   flags;
    logic          pc_load, nop_cycle, busy;
    logic [20:0]   pc_target;
    int            fails = 0;
    int            comparisons = 0;
    always #20 sys_clk = ~sys_clk;
    bbse_exec bbse_exec_i (.sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid),
        .instr_word(instr_word), .next_two_word(next_two_word), .pc_incr(pc_incr),
        .ext_set_en(ext_set_en), .bank_select_reg(bank_select_reg), .index_ptr(index_ptr),
        .mem_rdata(mem_rdata), .mem_req(mem_req), .acc(acc), .flags(flags),
        .pc_load(pc_load), .pc_target(pc_target), .nop_cycle(nop_cycle), .busy(busy));
    bbse_mem_model bbse_mem_model_i (.sys_clk(sys_clk), .mem_req(mem_req),
        .instr_word(instr_word), .ext_set_en(ext_set_en),
        .bank_select_reg(bank_select_reg), .index_ptr(index_ptr), .mem_rdata(mem_rdata));
    // compare and count
    task automatic check(input string what, input logic [20:0] seen, input logic [20:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one word offered for a single cycle
    task automatic run(input logic [15:0] w, input logic two);
        @(negedge sys_clk);
        instr_valid = 1'b1;
        instr_word = w;
        next_two_word = two;
        @(negedge sys_clk);
        instr_valid = 1'b0;
    endtask
    task automatic branch(input logic [15:0] w, input logic tk, input logic [20:0] tgt);
        run(w, 1'b0);
        check("pc_load", pc_load, tk);
        if (tk) check("pc_target", pc_target, tgt);
        @(negedge sys_clk);
        check("nop_cycle", nop_cycle, tk);
    endtask
    task automatic skip(input logic [15:0] w, input logic two, input logic sk);
        run(w, two);
        check("busy", busy, sk);
        repeat (sk ? (two ? 2 : 1) : 0) begin
            @(negedge sys_clk);
            check("nop_cycle", nop_cycle, 1'b1);
        end
        @(negedge sys_clk);
        check("nop_cycle", nop_cycle, 1'b0);
    endtask
    task automatic test_alu();
        bbse_mem_model_i.mem[12'h010] = 8'h4D;
        bbse_mem_model_i.mem[12'h320] = 8'h11;
        bbse_mem_model_i.mem[12'h205] = 8'h22;
        bbse_mem_model_i.mem[12'h321] = 8'hFF;
        run(16'h2010, 1'b0);
        check("acc", acc, 8'h4D);
        check("rd", mem_req.rd, 1'b1);
        run(16'h2210, 1'b0);
        check("wdata", mem_req.wdata, 8'h9A);
        check("waddr", mem_req.addr, 12'h010);
        check("acc", acc, 8'h4D);
        check("ov", flags.ov, 1'b1);
        run(16'h2120, 1'b0);
        check("acc", acc, 8'h5E);
        run(16'h2121, 1'b0);
        check("acc", acc, 8'h5D);
        check("c", flags.c, 1'b1);
        check("dc", flags.dc, 1'b1);
        ext_set_en = 1'b1;
        run(16'h2005, 1'b0);
        check("acc", acc, 8'h80);
        check("c", flags.c, 1'b0);
        check("n", flags.n, 1'b1);
        ext_set_en = 1'b0;
        run(16'h0B0F, 1'b0);
        check("acc", acc, 8'h00);
        check("z", flags.z, 1'b1);
        $display("test_alu done");
    endtask
    task automatic test_branch();
        branch(16'hE5FE, 1'b0, 21'h000000);
        branch(16'hE103, 1'b0, 21'h000000);
        run(16'h2010, 1'b0);
        branch(16'hE5FE, 1'b1, 21'h0000FC);
        branch(16'hE103, 1'b1, 21'h000106);
        $display("test_branch done");
    endtask
    task automatic test_skip();
        bbse_mem_model_i.mem[12'h030] = 8'h08;
        bbse_mem_model_i.mem[12'h040] = 8'h01;
        skip(16'hA630, 1'b1, 1'b1);
        skip(16'hA430, 1'b0, 1'b0);
        skip(16'hB630, 1'b0, 1'b0);
        skip(16'hB430, 1'b0, 1'b1);
        skip(16'h2E40, 1'b0, 1'b1);
        check("file", bbse_mem_model_i.mem[12'h040], 8'h00);
        skip(16'h2E40, 1'b0, 1'b0);
        skip(16'h4C40, 1'b0, 1'b1);
        check("acc", acc, 8'hFE);
        $display("test_skip done");
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // main sequence after four reset cycles
    initial begin
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        test_alu();
        test_branch();
        test_skip();
        report_and_stop();
    end
    // watchdog, well beyond the 56 cycles the tests need
    initial begin
        repeat (400) @(posedge sys_clk);
        fails++;
        report_and_stop();
    end
endmodule
`default_nettype wire
